// File: rlm_pkg.sv
// Purpose: constants for the readback select and dac load mode control block
// Assumes: 16-bit serial words, msb first, sampled on falling serial clock
// Notes:   only the readback/load-mode command is decoded; dac data writes arrive on ports
package rlm_pkg;
  localparam int          WORD_BITS     = 16;
  localparam int          CNT_BITS      = 5;
  localparam logic [4:0]  WORD_LAST     = 5'h10;
  localparam int          CMD_MSB       = 15;
  localparam int          ADDR_HI       = 14;
  localparam int          ADDR_LO       = 11;
  localparam int          RSV_HI        = 10;
  localparam int          RSV_LO        = 7;
  localparam int          EN_BIT        = 6;
  localparam int          SEL_HI        = 5;
  localparam int          SEL_LO        = 2;
  localparam int          MODE_HI       = 1;
  localparam int          MODE_LO       = 0;
  localparam logic [3:0]  ADDR_RBLM     = 4'h7;
  localparam logic [3:0]  RSV_ZERO      = 4'h0;
  localparam logic [3:0]  SEL_PD_REF    = 4'hB;
  localparam logic [3:0]  SEL_OPEN_DRN  = 4'hC;
  localparam logic [3:0]  SEL_TRISTATE  = 4'hD;
  localparam logic [3:0]  SEL_RESERVED  = 4'hE;
  localparam logic [3:0]  SEL_SW_RESET  = 4'hF;
  localparam logic [3:0]  SEL_RESET_VAL = 4'h0;
  typedef enum logic [1:0] {
    LOAD_IMMEDIATE = 2'b00,
    LOAD_HOLD      = 2'b01,
    LOAD_COPY_ALL  = 2'b10,
    LOAD_RESERVED  = 2'b11
  } rlm_mode_t;
endpackage : rlm_pkg

// File: rlm_ctrl.sv
// Purpose: readback selector and dac load mode control behind a 4-wire serial port
// Assumes: serial pins are asynchronous to clk and are sampled through two flip-flops
// Notes:   serial clock must stay below clk/4 so every edge is seen
// Behaviour
// - Selector codes 1011..1111 name power-down/reference, open-drain, three-state, reserved, reset.
// - Load mode 00 (reset default) copies each input register write straight to the dac register.
// - Load mode 01 updates only the input register and leaves dac registers unchanged.
// - Writing load mode 10 copies all input registers to the dac registers of all channels not written in the same cycle, in one update.
// - Each command is one 16-bit word, data sampled on the falling serial clock edge.
// - The link has serial clock, data in, data out and a host-driven frame select.
// - The command is bit 15 low with bits 14..11 equal to 0111, and bits 10..7 written zero.
// - With enable bit 6 set and a selector other than reserved 1110, the selected register goes out on the next transfer, then enable clears.
// - Load mode bits 1..0 other than reserved 11 take effect on every write whatever the enable bit.
`timescale 1ns/100ps
module rlm_ctrl
  import rlm_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter int DATA_W   = 12
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       clkEn,
  // serial link
  input  wire logic                       serClk,
  input  wire logic                       serSelN,
  input  wire logic                       serDin,
  output logic                            serDout,
  // dac input register writes from the command decoder
  input  wire logic                       inWrStb,
  input  wire logic [$clog2(CHANNELS)-1:0] inWrChan,
  input  wire logic [DATA_W-1:0]          inWrData,
  // readback source words, indexed by selector code
  input  wire logic [15:0][WORD_BITS-1:0] rbWords,
  // dac state and control outputs
  output logic [CHANNELS-1:0][DATA_W-1:0] dacReg,
  output logic                            dacUpdate,
  output logic [1:0]                      loadMode,
  output logic                            rbEnable,
  output logic [3:0]                      rbSelect,
  output logic                            swResetReq
);
  logic [2:0]               clkSync_ff;
  logic [1:0]               selSync_ff;
  logic [1:0]               dinSync_ff;
  logic [WORD_BITS-1:0]     shIn_ff;
  logic [WORD_BITS-1:0]     shOut_ff;
  logic [CNT_BITS-1:0]      bitCnt_ff;
  logic                     rbActive_ff;
  logic                     rbEn_ff;
  logic [3:0]               rbSel_ff;
  rlm_mode_t                mode_ff;
  logic [CHANNELS-1:0][DATA_W-1:0] inReg_ff;
  logic [CHANNELS-1:0][DATA_W-1:0] dacReg_ff;
  logic                     upd_ff;
  logic                     swRst_ff;
  logic                     serDout_ff;

  logic                     fallEdge;
  logic                     riseEdge;
  logic                     selActive;
  logic                     selSeen_ff;
  logic                     frameEnd;
  logic [WORD_BITS-1:0]     nxt_word;
  logic                     wordDone;
  logic                     cmdHit;
  logic                     copyAll;
  // one strobe decode per channel, compared at the channel index's own width
  localparam int            CHAN_W = $clog2(CHANNELS);
  logic [CHANNELS-1:0]      chanHit;

  // two-stage synchronisers; edges judged only between stages two and three
  always_ff @(posedge clk) begin
    if (rst) begin
      // serial clock idles high; a low start value would fake a rising edge
      clkSync_ff <= 3'h7;
      selSync_ff <= 2'h3;
      dinSync_ff <= 2'h0;
    end else if (clkEn) begin
      clkSync_ff <= {clkSync_ff[1:0], serClk};
      selSync_ff <= {selSync_ff[0], serSelN};
      dinSync_ff <= {dinSync_ff[0], serDin};
    end
  end

  assign fallEdge  = clkSync_ff[2] & ~clkSync_ff[1] & selActive;
  assign riseEdge  = ~clkSync_ff[2] & clkSync_ff[1] & selActive;
  assign selActive = ~selSync_ff[1];
  // frame end is seen a few clk late, so frames need a short gap between them
  assign frameEnd  = selSeen_ff & ~selActive;
  assign nxt_word  = {shIn_ff[WORD_BITS-2:0], dinSync_ff[1]};
  assign wordDone  = fallEdge && (bitCnt_ff == WORD_LAST - 5'h1);
  assign cmdHit    = wordDone && !nxt_word[CMD_MSB]
                     && nxt_word[ADDR_HI:ADDR_LO] == ADDR_RBLM;
  // copy-all is taken from the word just shifted in, so the dac registers of all channels not written in that cycle move on one edge
  assign copyAll   = cmdHit && nxt_word[MODE_HI:MODE_LO] == LOAD_COPY_ALL;

  // falling-edge shift in, sixteen bits to a word
  always_ff @(posedge clk) begin
    if (rst) begin
      shIn_ff    <= '0;
      bitCnt_ff  <= '0;
      selSeen_ff <= 1'b0;
    end else if (clkEn) begin
      selSeen_ff <= selActive;
      if (!selActive) begin
        bitCnt_ff <= '0;
      end else if (fallEdge) begin
        shIn_ff <= nxt_word;
        // bits after the sixteenth are ignored; the count parks at the word length
        if (bitCnt_ff != WORD_LAST) begin
          bitCnt_ff <= bitCnt_ff + 5'h1;
        end
      end
    end
  end

  // readback arm: enable held until the next frame has shifted the word out
  always_ff @(posedge clk) begin
    if (rst) begin
      rbEn_ff     <= 1'b0;
      rbSel_ff    <= SEL_RESET_VAL;
      rbActive_ff <= 1'b0;
    end else if (clkEn) begin
      // a reserved selector is refused outright and leaves the armed state as it was
      if (cmdHit && nxt_word[EN_BIT] && nxt_word[SEL_HI:SEL_LO] != SEL_RESERVED) begin
        rbEn_ff  <= 1'b1;
        rbSel_ff <= nxt_word[SEL_HI:SEL_LO];
        // re-arming inside the read frame restarts the wait, so the new request survives
        rbActive_ff <= 1'b0;
      end else if (rbActive_ff && frameEnd) begin
        rbEn_ff     <= 1'b0;
        rbActive_ff <= 1'b0;
      end else if (rbEn_ff && selActive && !selSeen_ff) begin
        rbActive_ff <= 1'b1;
      end
    end
  end

  // shift out on rising edges so data is steady at the host's falling sample
  always_ff @(posedge clk) begin
    if (rst) begin
      shOut_ff   <= '0;
      serDout_ff <= 1'b0;
    end else if (clkEn) begin
      if (selActive && !selSeen_ff) begin
        shOut_ff   <= rbEn_ff ? rbWords[rbSel_ff] : '0;
        serDout_ff <= rbEn_ff ? rbWords[rbSel_ff][WORD_BITS-1] : 1'b0;
      end else if (riseEdge && bitCnt_ff != '0) begin
        shOut_ff   <= {shOut_ff[WORD_BITS-2:0], 1'b0};
        serDout_ff <= shOut_ff[WORD_BITS-2];
      end
    end
  end

  // load mode; a reserved code leaves it unchanged
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_ff <= LOAD_IMMEDIATE;
    end else if (clkEn) begin
      if (cmdHit && nxt_word[MODE_HI:MODE_LO] != LOAD_RESERVED) begin
        mode_ff <= rlm_mode_t'(nxt_word[MODE_HI:MODE_LO]);
      end
    end
  end

  // software reset request when selector names the reset register
  // one-cycle request only; the wider reset sequence lives outside this block
  always_ff @(posedge clk) begin
    if (rst) begin
      swRst_ff <= 1'b0;
    end else if (clkEn) begin
      swRst_ff <= cmdHit && nxt_word[EN_BIT]
                  && nxt_word[SEL_HI:SEL_LO] == SEL_SW_RESET;
    end
  end

  // input and dac registers, one slice per channel
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      assign chanHit[ch] = inWrStb && (inWrChan == CHAN_W'(ch));
      always_ff @(posedge clk) begin
        if (rst) begin
          inReg_ff[ch]  <= '0;
          dacReg_ff[ch] <= '0;
        end else if (clkEn) begin
          if (chanHit[ch]) begin
            inReg_ff[ch] <= inWrData;
            if (mode_ff == LOAD_IMMEDIATE) begin
              dacReg_ff[ch] <= inWrData;
            end
          end else if (copyAll) begin
            // a channel written in the same cycle skips the copy; its dac register takes the new data only if the old mode is immediate
            dacReg_ff[ch] <= inReg_ff[ch];
          end
        end
      end
    end
  endgenerate

  // one update pulse marks every change of the dac registers
  always_ff @(posedge clk) begin
    if (rst) begin
      upd_ff <= 1'b0;
    end else if (clkEn) begin
      // pulse rises on the same edge as the dac registers, so a watcher sees both together
      upd_ff <= (inWrStb && mode_ff == LOAD_IMMEDIATE)
                || copyAll;
    end
  end

  assign serDout    = serDout_ff;
  assign dacReg     = dacReg_ff;
  assign dacUpdate  = upd_ff;
  assign loadMode   = mode_ff;
  assign rbEnable   = rbEn_ff;
  assign rbSelect   = rbSel_ff;
  assign swResetReq = swRst_ff;
endmodule : rlm_ctrl

// File: rlm_ctrl_props.sv
// Purpose: port-level checks for rlm_ctrl
// Assumes: clkEn held high by the bench
// Notes:   bound to every rlm_ctrl at the foot of this file
`timescale 1ns/100ps
module rlm_ctrl_props
  import rlm_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter int DATA_W   = 12
) (
  // watched ports
  input wire logic                          clk,
  input wire logic                          rst,
  input wire logic                          serSelN,
  input wire logic                          inWrStb,
  input wire logic [$clog2(CHANNELS)-1:0]   inWrChan,
  input wire logic [DATA_W-1:0]             inWrData,
  input wire logic [CHANNELS-1:0][DATA_W-1:0] dacReg,
  input wire logic                          dacUpdate,
  input wire logic [1:0]                    loadMode,
  input wire logic                          rbEnable,
  input wire logic [3:0]                    rbSelect,
  input wire logic                          swResetReq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_dacChange; $changed(dacReg); endsequence
  sequence s_copyCmd; $changed(loadMode) && loadMode == LOAD_COPY_ALL; endsequence
  // the update pulse and the dac registers are launched on the same edge
  property p_update; s_dacChange |-> dacUpdate; endproperty
  a_update: assert property (p_update) else $error("dac change not flagged");
  property p_copy; s_copyCmd |-> dacUpdate; endproperty
  a_copy: assert property (p_copy) else $error("copy all not flagged");
  property p_imm; inWrStb && loadMode == LOAD_IMMEDIATE
    |=> dacReg[$past(inWrChan)] == $past(inWrData); endproperty
  a_imm: assert property (p_imm) else $error("immediate write not copied");
  property p_hold; inWrStb && loadMode == LOAD_HOLD |=> $stable(dacReg) || $changed(loadMode);
  endproperty
  a_hold: assert property (p_hold) else $error("held write reached dac");
  property p_legal; loadMode != LOAD_RESERVED; endproperty
  a_legal: assert property (p_legal) else $error("reserved load mode taken");
  property p_rsv; rbEnable |-> rbSelect != SEL_RESERVED; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved selector armed");
  property p_swr; swResetReq |=> !swResetReq; endproperty
  a_swr: assert property (p_swr) else $error("reset request too long");
  // enable may only drop once the readback frame has closed
  property p_clear; $fell(rbEnable) |-> serSelN; endproperty
  a_clear: assert property (p_clear) else $error("enable cleared inside frame");
endmodule : rlm_ctrl_props
bind rlm_ctrl rlm_ctrl_props #(.CHANNELS(CHANNELS), .DATA_W(DATA_W)) rlm_ctrl_props_i (.clk,
  .rst, .serSelN, .inWrStb, .inWrChan, .inWrData, .dacReg, .dacUpdate, .loadMode, .rbEnable,
  .rbSelect, .swResetReq);

// File: rlm_host.sv
// Purpose: serial host model driving 16-bit frames
// Assumes: called at a falling clk edge, 800 ns serial period
// Notes:   serial clock idles high and stands still between frames
`timescale 1ns/100ps
module rlm_host (
  // serial link
  output logic      serClk,
  output logic      serSelN,
  output logic      serDin,
  input  wire logic serDout
);
  initial begin
    serClk = 1'b1;
    serSelN = 1'b1;
    serDin = 1'b0;
  end
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    serSelN = 1'b0;
    #400;
    for (int i = 15; i >= 0; i--) begin
      serDin = w[i];
      #400;
      serClk = 1'b0;
      r[i] = serDout;
      #400;
      serClk = 1'b1;
    end
    #400;
    serSelN = 1'b1;
    // released line flips so a stale bit never looks valid
    serDin = ~serDin;
    #800;
  endtask : xfer
endmodule : rlm_host

// File: tb.sv
// Purpose: self-checking bench for rlm_ctrl
// Assumes: default parameters, clkEn held high
// Notes:   reference model kept in integer arrays
`timescale 1ns/100ps
module tb;
  import rlm_pkg::*;
  logic             clk, rst, inWrStb, serClk, serSelN, serDin, serDout;
  logic             dacUpdate, rbEnable, swResetReq;
  logic [2:0]       inWrChan;
  logic [11:0]      inWrData;
  logic [15:0][15:0] rbWords;
  logic [7:0][11:0] dacReg;
  logic [1:0]       loadMode;
  logic [3:0]       rbSelect;
  logic [15:0]      rd;
  int               fails, check_count, seed, mode;
  int               inReg[8], dacExp[8];
  int               updCount = 0, updExp = 0, swrCount = 0, swrExp = 0;
  rlm_ctrl rlm_ctrl_i (.clk, .rst, .clkEn(1'b1), .serClk, .serSelN, .serDin, .serDout, .inWrStb,
    .inWrChan, .inWrData, .rbWords, .dacReg, .dacUpdate, .loadMode, .rbEnable, .rbSelect,
    .swResetReq);
  rlm_host rlm_host_i (.serClk, .serSelN, .serDin, .serDout);
  // one-cycle pulses counted at the falling edge, where they are settled
  always @(negedge clk) begin
    if (!rst && dacUpdate === 1'b1) updCount++;
    if (!rst && swResetReq === 1'b1) swrCount++;
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic dchk;
    for (int c = 0; c < 8; c++) chk(dacReg[c], dacExp[c]);
  endtask : dchk
  task automatic wr(input int ch);
    inWrChan = ch[2:0];
    inWrData = 12'($random(seed));
    inWrStb = 1'b1;
    inReg[ch] = inWrData;
    if (mode == 0) begin
      dacExp[ch] = inWrData;
      updExp++;
    end
    @(negedge clk);
    inWrStb = 1'b0;
    @(negedge clk);
  endtask : wr
  task automatic cmd(input logic en, input logic [3:0] sel, input logic [1:0] m);
    rlm_host_i.xfer({1'b0, ADDR_RBLM, RSV_ZERO, en, sel, m}, rd);
    if (m != 2'b11) mode = m;
    if (m == 2'b10) begin
      dacExp = inReg;
      updExp++;
    end
    if (en && sel == SEL_SW_RESET) swrExp++;
    repeat (6) @(negedge clk);
  endtask : cmd
  task automatic test_done;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  initial begin
    #2000000;
    fails++;
    test_done;
  end
  initial begin
    seed = 32'hE3E1E745;
    fails = 0;
    check_count = 0;
    mode = 0;
    rst = 1'b1;
    inWrStb = 1'b0;
    inWrChan = 3'h0;
    inWrData = 12'h000;
    for (int i = 0; i < 16; i++) rbWords[i] = 16'($random(seed));
    for (int i = 0; i < 8; i++) inReg[i] = 0;
    dacExp = inReg;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk(loadMode, 16'h0000);
    for (int c = 0; c < 8; c++) wr(c);
    dchk;
    $display("test immediate done");
    cmd(1'b0, 4'h0, 2'b01);
    for (int c = 0; c < 8; c++) wr(c);
    dchk;
    cmd(1'b0, 4'h0, 2'b11);
    chk(loadMode, mode);
    rlm_host_i.xfer(16'h3002, rd);
    repeat (6) @(negedge clk);
    chk(loadMode, mode);
    cmd(1'b0, 4'h0, 2'b10);
    dchk;
    $display("test load modes done");
    for (int s = 11; s < 16; s++) if (s != 14) begin
      cmd(1'b1, s[3:0], 2'b00);
      chk(rbSelect, s);
      chk(loadMode, mode);
      cmd(1'b0, 4'h0, 2'b00);
      chk(rd, rbWords[s]);
      chk(rbEnable, 16'h0000);
    end
    cmd(1'b1, SEL_RESERVED, 2'b00);
    chk(rbEnable, 16'h0000);
    chk(16'(updCount), 16'(updExp));
    chk(16'(swrCount), 16'(swrExp));
    $display("test readback done");
    test_done;
  end
endmodule : tb
